// ==== hdl/cisrc_cpu_ctrl.sv ====
// Purpose: Processor end: state sequencing, interrupt acknowledge, start-up clearing, ready waits.
// Assumes: RST stands in for power-up; the far end keeps its own link duties.
// Notes: Only halt, restart and jump opcodes change flow; all others fall through as one cycle.
`timescale 1ns/1ps
`default_nettype none
module cisrc_cpu_ctrl #(
    parameter int STACK_DEPTH = cisrc_pkg::STACK_DEPTH,
    parameter int SCRATCH_REGS = cisrc_pkg::SCRATCH_REGS
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    cisrc_link_if.dev LINK,
    input wire logic [2:0] REG_SEL,
    output logic [7:0] REG_DATA,
    output logic [7:0] ACC_OUT,
    output logic [cisrc_pkg::PC_W-1:0] PC_OUT,
    output logic [7:0] IR_OUT,
    output logic START_FLAG,
    output logic CLEAR_BUSY
);
    import cisrc_pkg::*;

    // ********************************************************************
    // Storage
    // ********************************************************************
    cisrc_state_t state_q, state_d;
    logic phase_q;
    logic [7:0] ir_q;
    logic [PC_W-1:0] pc_q, pc_d;
    logic [1:0] cyc_q, cyc_d;
    logic [1:0] byte_q, byte_d;
    logic [7:0] tmp_q;
    logic start_q;
    logic [4:0] clr_cnt_q;
    logic [7:0] acc_q;
    logic [7:0] scratch_q [SCRATCH_REGS];
    logic [PC_W-1:0] stack_q [STACK_DEPTH];
    logic [2:0] sp_q;
    logic [7:0] do_q, do_d;
    logic oe_q;

    // ********************************************************************
    // Decode
    // ********************************************************************
    wire logic adv = phase_q;
    wire logic clr_busy = (clr_cnt_q != CLR_PERIODS);
    wire logic [7:0] din = LINK.bus;
    wire logic rdy = LINK.ready;
    wire logic is_fetch = (cyc_q == CYC_FETCH);
    wire logic op_halt = (din[7:1] == 7'h00) || (din == OP_HALT_ALT);
    wire logic op_rst = (din[7:6] == 2'h0) && (din[2:0] == OP_RST_LOW);
    wire logic op_jmp = (din[7:6] == 2'h1) && (din[2:0] == OP_JMP_LOW);
    wire logic xfer_end = adv && (state_q == ST_XFER);
    wire logic do_push = xfer_end && is_fetch && op_rst;
    wire logic next_fetch = is_fetch ? !op_jmp : (byte_q == 2'h2);
    wire logic [2:0] clr_idx = clr_cnt_q[2:0];

    // Any opcode runs the same whether it came from memory or was jammed in.
    wire logic halt_now = is_fetch && op_halt;

    // ********************************************************************
    // State sequencing
    // ********************************************************************
    // States advance only on the second period of each state, so each lasts two clocks.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_T1, ST_ACK: begin
                state_d = ST_T2;
            end
            ST_T2, ST_WAIT: begin
                state_d = rdy ? ST_XFER : ST_WAIT;
            end
            ST_XFER: begin
                if (halt_now) begin
                    state_d = ST_STOP;
                end else if (next_fetch && LINK.int_req) begin
                    state_d = ST_ACK;
                end else begin
                    state_d = ST_T1;
                end
            end
            ST_STOP: begin
                // Clearing must finish before an interrupt can release the stop.
                state_d = (LINK.int_req && !clr_busy) ? ST_ACK : ST_STOP;
            end
            default: begin
                state_d = ST_STOP;
            end
        endcase
    end

    // ********************************************************************
    // Program counter, cycle type and byte count
    // ********************************************************************
    // The acknowledge state leaves the counter alone so the same address goes out twice.
    always_comb begin
        pc_d = pc_q;
        cyc_d = cyc_q;
        byte_d = byte_q;
        if (clr_busy) begin
            pc_d = '0;
        end else if (adv && state_q == ST_T1) begin
            pc_d = pc_q + 14'h0001;
        end else if (adv && state_q == ST_ACK) begin
            pc_d = pc_q;
        end else if (xfer_end && is_fetch) begin
            if (op_rst) begin
                pc_d = {8'h00, din[5:3], 3'h0};
            end else if (op_jmp) begin
                cyc_d = CYC_READ;
                byte_d = 2'h1;
            end
        end else if (xfer_end) begin
            if (byte_q == 2'h2) begin
                pc_d = {din[5:0], tmp_q};
                cyc_d = CYC_FETCH;
                byte_d = 2'h0;
            end else begin
                byte_d = 2'h2;
            end
        end
    end

    // ********************************************************************
    // Bus drive values
    // ********************************************************************
    // Low address in the first state, cycle type and high address in the second.
    assign do_d = (state_d == ST_T2) ? {cyc_d, pc_q[13:8]} : pc_d[7:0];

    // ********************************************************************
    // Sequencer registers
    // ********************************************************************
    // Power-up forces a halt into the instruction register and parks in stop.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state_q <= ST_STOP;
            phase_q <= 1'b0;
            ir_q <= RESET_IR;
            start_q <= 1'b1;
            cyc_q <= CYC_FETCH;
            byte_q <= 2'h0;
            do_q <= 8'h00;
            oe_q <= 1'b0;
        end else begin
            phase_q <= !phase_q;
            cyc_q <= cyc_d;
            byte_q <= byte_d;
            if (adv) begin
                state_q <= state_d;
                do_q <= do_d;
                // Bus floats in wait, transfer and stop; drivers on only for address.
                oe_q <= (state_d == ST_T1) || (state_d == ST_ACK) || (state_d == ST_T2);
            end
            if (xfer_end && is_fetch) begin
                ir_q <= din;
            end
            if (adv && state_q == ST_STOP && state_d == ST_ACK) begin
                start_q <= 1'b0;
            end
        end
    end

    // ********************************************************************
    // Counter, jump operand and clear sequencing
    // ********************************************************************
    // One clear step per clock, sixteen in all, before the device is usable.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            pc_q <= '0;
            tmp_q <= 8'h00;
            clr_cnt_q <= 5'h00;
            acc_q <= 8'h00;
            sp_q <= 3'h0;
        end else begin
            pc_q <= pc_d;
            if (clr_busy) begin
                clr_cnt_q <= clr_cnt_q + 5'h01;
                acc_q <= 8'h00;
                sp_q <= 3'h0;
            end else if (do_push) begin
                sp_q <= sp_q + 3'h1;
            end
            if (xfer_end && !is_fetch && byte_q == 2'h1) begin
                tmp_q <= din;
            end
        end
    end

    // ********************************************************************
    // Address stack and scratch registers
    // ********************************************************************
    // The stack wraps after eight pushes; nesting deeper overwrites the oldest entry.
    for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
        always_ff @(posedge CORE_CLK) begin
            if (clr_busy && clr_idx == 3'(i)) begin
                stack_q[i] <= '0;
            end else if (do_push && sp_q == 3'(i)) begin
                stack_q[i] <= pc_q;
            end
        end
    end

    // Scratch registers have no writer here beyond the start-up clear.
    for (genvar i = 0; i < SCRATCH_REGS; i++) begin : g_scratch
        always_ff @(posedge CORE_CLK) begin
            if (clr_busy && clr_idx == 3'(i)) begin
                scratch_q[i] <= 8'h00;
            end
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    // State code is a pure decode of the state register.
    assign LINK.state_code_out = (state_q == ST_T1) ? SC_T1 :
                                 (state_q == ST_ACK) ? SC_ACK :
                                 (state_q == ST_T2) ? SC_T2 :
                                 (state_q == ST_WAIT) ? SC_WAIT :
                                 (state_q == ST_XFER) ? SC_XFER : SC_STOP;
    assign LINK.sync = phase_q;
    assign LINK.dev_do = do_q;
    assign LINK.dev_oe = oe_q;
    assign REG_DATA = (REG_SEL < 3'(SCRATCH_REGS)) ? scratch_q[REG_SEL] : stack_q[sp_q][7:0];
    assign ACC_OUT = acc_q;
    assign PC_OUT = pc_q;
    assign IR_OUT = ir_q;
    assign START_FLAG = start_q;
    assign CLEAR_BUSY = clr_busy;

endmodule : cisrc_cpu_ctrl
`default_nettype wire

// ==== hdl/cisrc_pkg.sv ====
// Purpose: Shared constants and types for the processor interrupt, start-up and ready control.
// Assumes: One 20 MHz clock CORE_CLK; each processor state lasts two clock periods.
// Notes: Both link ends import this package.
// How it works
// - Interrupt taken at next fetch, code 011.
// - Acknowledge fetch sends address, PC held.
// - Far end jams byte, owns bus choice.
// - Far end raises interrupt only first cycle.
// - Far end aligns interrupt to phase start.
// - Jammed instruction executes like any other.
// - Power-up sets start flag, halt opcode, stopped.
// - Sixteen periods clear accumulator, scratch, PC, stack.
// - Far end keeps interrupt low while clearing.
// - Interrupt high exits stop, dropped after acknowledge.
// - Acknowledge suppresses PC increment, address repeats.
// - Opcode 00xyz101 calls address xyz000.
// - Memory access waits until ready high.
// - Fast memory may tie ready high.
// - Far end may step cycles with ready.
// - Wait and stopped states float data bus.
// - Each state two periods, sync marks halves.
// - Wait state waits for ready, refreshing.
// - Halt cycles in transfer state, shows stopped.
package cisrc_pkg;

    // ********************
    // Sizes and counts
    // ********************
    localparam int PC_W = 14;
    localparam int STACK_DEPTH = 8;
    localparam int SCRATCH_REGS = 7;
    localparam logic [4:0] CLR_PERIODS = 5'h10;

    // ********************
    // State codes on the link, bit 2 first line, bit 0 last line
    // ********************
    localparam logic [2:0] SC_T1 = 3'h2;
    localparam logic [2:0] SC_ACK = 3'h3;
    localparam logic [2:0] SC_T2 = 3'h4;
    localparam logic [2:0] SC_WAIT = 3'h0;
    localparam logic [2:0] SC_XFER = 3'h1;
    localparam logic [2:0] SC_STOP = 3'h6;

    // ********************
    // Cycle type bits sent in the upper address byte
    // ********************
    localparam logic [1:0] CYC_FETCH = 2'h0;
    localparam logic [1:0] CYC_READ = 2'h2;

    // ********************
    // Opcodes and reset values
    // ********************
    localparam logic [7:0] OP_HALT_ALT = 8'hff;
    localparam logic [2:0] OP_RST_LOW = 3'h5;
    localparam logic [2:0] OP_JMP_LOW = 3'h4;
    localparam logic [7:0] RESET_IR = 8'h00;

    typedef enum logic [2:0] {
        ST_T1 = 3'b000,
        ST_ACK = 3'b001,
        ST_T2 = 3'b010,
        ST_WAIT = 3'b011,
        ST_XFER = 3'b100,
        ST_STOP = 3'b101
    } cisrc_state_t;

endpackage : cisrc_pkg

// ==== hdl/cisrc_link_if.sv ====
// Purpose: Link between the processor end and the interrupt and memory logic end.
// Assumes: Both ends run on the same clock.
// Notes: The shared data bus level is resolved here from the two enables.
`timescale 1ns/1ps
`default_nettype none
interface cisrc_link_if;
    logic [7:0] dev_do;
    logic dev_oe;
    logic [7:0] host_do;
    logic host_oe;
    logic [7:0] bus;
    logic int_req;
    logic ready;
    logic [2:0] state_code_out;
    logic sync;

    // Undriven bus reads as all ones, as pull-ups would give.
    assign bus = dev_oe ? dev_do : (host_oe ? host_do : 8'hff);

    modport dev (output dev_do, output dev_oe, output state_code_out, output sync,
                 input bus, input int_req, input ready);
    modport host (output host_do, output host_oe, output int_req, output ready,
                  input bus, input state_code_out, input sync);
endinterface : cisrc_link_if
`default_nettype wire

// ==== hdl/cisrc_jam_ctrl.sv ====
// Purpose: Far end: interrupt jamming, memory hand-off and ready generation.
// Assumes: Memory answers MEM_REQ with MEM_RVALID some cycles later.
// Notes: FAST_MEM ties ready high; memory must then answer within one clock.
`timescale 1ns/1ps
`default_nettype none
module cisrc_jam_ctrl #(
    parameter bit FAST_MEM = 1'b0
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    cisrc_link_if.host LINK,
    input wire logic JAM_REQ,
    input wire logic [7:0] JAM_OPCODE,
    output logic JAM_BUSY,
    input wire logic STEP_MODE,
    input wire logic STEP_PULSE,
    output logic [cisrc_pkg::PC_W-1:0] MEM_ADDR,
    output logic [1:0] MEM_CTL,
    output logic MEM_REQ,
    input wire logic [7:0] MEM_RDATA,
    input wire logic MEM_RVALID
);
    import cisrc_pkg::*;

    // ********************
    // Storage and decode
    // ********************
    logic jam_pend_q, int_q, jam_cyc_q, data_ok_q, step_ok_q, req_q;
    logic [4:0] hold_cnt_q;
    logic [7:0] jam_op_q, data_q, alo_q;
    logic [5:0] ahi_q;
    logic [1:0] ctl_q;
    wire logic [2:0] sc = LINK.state_code_out;
    wire logic late = LINK.sync;
    wire logic in_ack = (sc == SC_ACK);
    wire logic xfer_done = (sc == SC_XFER) && late;
    wire logic hold_low = (hold_cnt_q != CLR_PERIODS);

    // ********************
    // Interrupt request and jam bookkeeping
    // ********************
    // Interrupt changes only with the state boundary and drops once acknowledge shows.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            jam_pend_q <= 1'b0;
            int_q <= 1'b0;
            jam_cyc_q <= 1'b0;
            jam_op_q <= 8'h00;
            hold_cnt_q <= 5'h00;
        end else begin
            if (hold_low) begin
                hold_cnt_q <= hold_cnt_q + 5'h01;
            end
            if (JAM_REQ && !jam_pend_q) begin
                jam_pend_q <= 1'b1;
                jam_op_q <= JAM_OPCODE;
            end else if (in_ack) begin
                jam_pend_q <= 1'b0;
            end
            if (late) begin
                int_q <= jam_pend_q && !in_ack && !hold_low;
            end
            if (in_ack) begin
                jam_cyc_q <= 1'b1;
            end else if (xfer_done) begin
                jam_cyc_q <= 1'b0;
            end
        end
    end

    // ********************
    // Address capture and memory data
    // ********************
    // A jammed cycle never asks memory; the inserted byte replaces it.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            alo_q <= 8'h00;
            ahi_q <= 6'h00;
            ctl_q <= 2'h0;
            req_q <= 1'b0;
            data_q <= 8'h00;
            data_ok_q <= 1'b0;
            step_ok_q <= 1'b0;
        end else begin
            req_q <= (sc == SC_T2) && late && !jam_cyc_q;
            if (sc == SC_T1 || in_ack) begin
                alo_q <= LINK.bus;
            end
            if (sc == SC_T2) begin
                ahi_q <= LINK.bus[5:0];
                ctl_q <= LINK.bus[7:6];
            end
            if (MEM_RVALID) begin
                data_q <= MEM_RDATA;
            end
            // A new event wins over the end-of-transfer clear so no pulse is lost.
            if (MEM_RVALID) begin
                data_ok_q <= 1'b1;
            end else if (xfer_done) begin
                data_ok_q <= 1'b0;
            end
            if (STEP_PULSE) begin
                step_ok_q <= 1'b1;
            end else if (xfer_done) begin
                step_ok_q <= 1'b0;
            end
        end
    end

    // ********************
    // Link outputs
    // ********************
    // Stepping holds ready low until one pulse per machine cycle.
    assign LINK.ready = (FAST_MEM || data_ok_q || jam_cyc_q) && (!STEP_MODE || step_ok_q);
    assign LINK.int_req = int_q;
    assign LINK.host_oe = (sc == SC_XFER) && (ctl_q == CYC_FETCH || ctl_q == CYC_READ);
    assign LINK.host_do = jam_cyc_q ? jam_op_q : data_q;
    assign JAM_BUSY = jam_pend_q || jam_cyc_q;
    assign MEM_ADDR = {ahi_q, alo_q};
    assign MEM_CTL = ctl_q;
    assign MEM_REQ = req_q;

endmodule : cisrc_jam_ctrl
`default_nettype wire

// ==== verif/cisrc_link_properties.sv ====
// Purpose: Concurrent checks on the link between the processor end and the jam end.
// Assumes: One clock domain; RST synchronous, active high.
// Notes: Instantiated beside the link and sees only link signals.
`timescale 1ns/1ps
`default_nettype none
module cisrc_link_properties (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic dev_oe,
    input wire logic [7:0] bus,
    input wire logic int_req,
    input wire logic ready,
    input wire logic [2:0] state_code_out,
    input wire logic sync
);
    import cisrc_pkg::*;
    // ********************
    // State decodes
    // ********************
    // Named decodes keep each property down to one idea.
    wire st_stop = (state_code_out == SC_STOP);
    wire st_ack = (state_code_out == SC_ACK);
    wire st_t2 = (state_code_out == SC_T2);
    wire st_wait = (state_code_out == SC_WAIT);
    wire st_xfer = (state_code_out == SC_XFER);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    // ********************
    // Properties
    // ********************
    // The half marker flips every clock and a state holds over both of its clocks.
    property p_sync_toggle;
        !$past(RST) |-> sync != $past(sync);
    endproperty
    a_sync_toggle: assert property (p_sync_toggle) else $error("half marker did not flip");
    property p_state_pair;
        !sync |=> $stable(state_code_out);
    endproperty
    a_state_pair: assert property (p_state_pair) else $error("state changed mid state");
    // A floating bus in wait and stop lets memory or jam logic own it safely.
    property p_float;
        st_wait || st_stop |-> !dev_oe;
    endproperty
    a_float: assert property (p_float) else $error("bus driven in wait or stop");
    // Acknowledge is entered only at a marker edge with the request high, from a fetch boundary.
    property p_ack_cause;
        st_ack && !$past(st_ack) |-> $past(int_req) && $past(sync);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without request");
    property p_ack_from;
        st_ack && !$past(st_ack) |-> $past(st_xfer) || $past(st_stop);
    endproperty
    a_ack_from: assert property (p_ack_from) else $error("acknowledge inside an instruction");
    // The acknowledge cycle still sends both address bytes as a fetch.
    sequence s_ack_out;
        st_ack && dev_oe;
    endsequence
    sequence s_fetch_t2;
        st_t2 && dev_oe && bus[7:6] == CYC_FETCH;
    endsequence
    property p_ack_addr;
        st_ack && !sync |-> s_ack_out ##1 (s_ack_out and sync) ##1 s_fetch_t2 [*2];
    endproperty
    a_ack_addr: assert property (p_ack_addr) else $error("acknowledge address missing");
    // Ready decides between another wait and the transfer state.
    property p_wait_stay;
        sync && (st_t2 || st_wait) && !ready |=> st_wait [*2];
    endproperty
    a_wait_stay: assert property (p_wait_stay) else $error("wait left without ready");
    property p_wait_exit;
        sync && (st_t2 || st_wait) && ready |=> st_xfer;
    endproperty
    a_wait_exit: assert property (p_wait_exit) else $error("ready did not start transfer");
    // Stop holds until the request and then goes straight to acknowledge.
    property p_stop_hold;
        sync && st_stop && !int_req |=> st_stop [*2];
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop left without request");
    property p_stop_exit;
        sync && st_stop && int_req |=> st_ack;
    endproperty
    a_stop_exit: assert property (p_stop_exit) else $error("request did not leave stop");
    // After reset the device stays stopped through the clearing time, bus released for the first eight clocks.
    property p_startup;
        $fell(RST) |-> (st_stop && !dev_oe) [*8] ##1 st_stop [*8];
    endproperty
    a_startup: assert property (p_startup) else $error("start-up stop too short");
endmodule : cisrc_link_properties
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the processor end and the jam end on one link.
// Assumes: 50 ns clock; the memory model answers each request after mem_lat clocks.
// Notes: A second processor end faces the bench directly so far-side faults can be made.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cisrc_pkg::*;
    // ********************
    // Signals and instances
    // ********************
    logic core_clk, rst, start_flag, clear_busy, jam_req, jam_busy, step_mode, step_pulse;
    logic mem_req, start_flag_b;
    logic mem_rvalid = 1'b0;
    logic [2:0] reg_sel;
    logic [7:0] reg_data, acc_out, ir_out, jam_opcode, a0;
    logic [7:0] mem_rdata = 8'h00;
    logic [7:0] mem [0:255];
    logic [1:0] mem_ctl;
    logic [PC_W-1:0] pc_out, mem_addr, pc0;
    int mem_lat = 2;
    int lat_cnt = 0;
    int bad_count = 0;
    int n_compared = 0;
    cisrc_link_if link();
    cisrc_link_if link_b();
    cisrc_cpu_ctrl u_cisrc_cpu_ctrl (.CORE_CLK(core_clk), .RST(rst), .LINK(link), .REG_SEL(reg_sel),
        .REG_DATA(reg_data), .ACC_OUT(acc_out), .PC_OUT(pc_out), .IR_OUT(ir_out),
        .START_FLAG(start_flag), .CLEAR_BUSY(clear_busy));
    cisrc_jam_ctrl u_cisrc_jam_ctrl (.CORE_CLK(core_clk), .RST(rst), .LINK(link), .JAM_REQ(jam_req),
        .JAM_OPCODE(jam_opcode), .JAM_BUSY(jam_busy), .STEP_MODE(step_mode), .STEP_PULSE(step_pulse),
        .MEM_ADDR(mem_addr), .MEM_CTL(mem_ctl), .MEM_REQ(mem_req), .MEM_RDATA(mem_rdata),
        .MEM_RVALID(mem_rvalid));
    cisrc_cpu_ctrl u_cisrc_cpu_ctrl_b (.CORE_CLK(core_clk), .RST(rst), .LINK(link_b), .REG_SEL(3'h0),
        .REG_DATA(), .ACC_OUT(), .PC_OUT(), .IR_OUT(), .START_FLAG(start_flag_b), .CLEAR_BUSY());
    cisrc_link_properties u_cisrc_link_properties (.CORE_CLK(core_clk), .RST(rst), .dev_oe(link.dev_oe),
        .bus(link.bus), .int_req(link.int_req), .ready(link.ready), .state_code_out(link.state_code_out),
        .sync(link.sync));
    // ********************
    // Tasks
    // ********************
    // Compares one value with case equality so an unknown never matches.
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Steps at least one clock, then waits, bounded, for the first clock of a state.
    task automatic wait_state(input logic [2:0] code, input int limit);
        int i;
        i = 0;
        @(negedge core_clk);
        while (!(link.state_code_out === code && link.sync === 1'b0) && i < limit) begin
            @(negedge core_clk);
            i++;
        end
        check("state reached", 16'(code), 16'(link.state_code_out));
    endtask : wait_state
    // Hands one opcode to the jam end for the next fetch.
    task automatic jam(input logic [7:0] op);
        jam_opcode = op;
        jam_req = 1'b1;
        @(negedge core_clk);
        jam_req = 1'b0;
    endtask : jam
    task automatic test_done();
        $display("Compared %0d, mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    // ********************
    // Clock, memory and watchdog
    // ********************
    // Free-running 20 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Memory answers after mem_lat clocks and scrambles its data otherwise, so no stale byte helps.
    always @(negedge core_clk) begin
        mem_rvalid <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req) begin
            lat_cnt <= mem_lat;
        end else if (lat_cnt == 1) begin
            mem_rvalid <= 1'b1;
            mem_rdata <= mem[mem_addr[7:0]];
            lat_cnt <= 0;
        end else if (lat_cnt > 1) begin
            lat_cnt <= lat_cnt - 1;
        end
    end
    // The tests need about four hundred clocks; five thousand means a hang.
    initial begin
        #(50 * 5000);
        bad_count++;
        $display("[FAIL] watchdog expected finish seen hang");
        test_done();
    end
    // ********************
    // Main sequence
    // ********************
    // Reset, start-up, restarts, repeated address, waits, stepping, halt and jump.
    initial begin
        rst = 1'b1;
        reg_sel = 3'h0;
        jam_req = 1'b0;
        jam_opcode = 8'h00;
        step_mode = 1'b0;
        step_pulse = 1'b0;
        link_b.host_do = 8'h00;
        link_b.host_oe = 1'b0;
        link_b.int_req = 1'b0;
        link_b.ready = 1'b0;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'hc0;
        end
        repeat (5) @(negedge core_clk);
        check("ir", 16'h0000, 16'(ir_out));
        check("start flag", 16'h0001, 16'(start_flag));
        check("state", 16'(SC_STOP), 16'(link.state_code_out));
        check("bus enable", 16'h0000, 16'(link.dev_oe));
        rst = 1'b0;
        // The second end sees the request during clearing, which it must ignore.
        link_b.int_req = 1'b1;
        repeat (2) @(negedge core_clk);
        check("clear busy", 16'h0001, 16'(clear_busy));
        repeat (10) @(negedge core_clk);
        check("early request flag", 16'h0001, 16'(start_flag_b));
        check("early request state", 16'(SC_STOP), 16'(link_b.state_code_out));
        repeat (8) @(negedge core_clk);
        check("clear done", 16'h0000, 16'(clear_busy));
        for (int i = 0; i < 7; i++) begin
            reg_sel = 3'(i);
            @(negedge core_clk);
            check("scratch", 16'h0000, 16'(reg_data));
        end
        check("acc", 16'h0000, 16'(acc_out));
        check("pc", 16'h0000, 16'(pc_out));
        repeat (20) @(negedge core_clk);
        check("late request state", 16'(SC_WAIT), 16'(link_b.state_code_out));
        check("late request flag", 16'h0000, 16'(start_flag_b));
        check("floating bus", 16'h00ff, 16'(link_b.bus));
        jam(8'h2d);
        wait_state(SC_ACK, 200);
        wait_state(SC_T1, 100);
        check("start flag", 16'h0000, 16'(start_flag));
        check("restart address", 16'h0028, 16'(link.bus));
        check("restart ir", 16'h002d, 16'(ir_out));
        for (int v = 0; v < 8; v++) begin
            jam({2'b00, 3'(v), 3'b101});
            wait_state(SC_ACK, 100);
            wait_state(SC_T1, 100);
            check("restart vector", 16'(v * 8), 16'(link.bus));
        end
        jam(8'hc0);
        wait_state(SC_ACK, 100);
        a0 = link.bus;
        pc0 = pc_out;
        wait_state(SC_T1, 100);
        check("repeated address", 16'(a0), 16'(link.bus));
        check("pc held", 16'(pc0), 16'(pc_out));
        check("request dropped", 16'h0000, 16'(link.int_req));
        wait_state(SC_T1, 100);
        check("next address", 16'(a0 + 8'h01), 16'(link.bus));
        mem_lat = 6;
        wait_state(SC_WAIT, 100);
        check("wait bus", 16'h00ff, 16'(link.bus));
        step_mode = 1'b1;
        repeat (40) @(negedge core_clk);
        pc0 = pc_out;
        step_pulse = 1'b1;
        @(negedge core_clk);
        step_pulse = 1'b0;
        repeat (40) @(negedge core_clk);
        check("stepped state", 16'(SC_WAIT), 16'(link.state_code_out));
        check("one step", 16'(pc0 + 1'b1), 16'(pc_out));
        step_mode = 1'b0;
        mem_lat = 2;
        jam(8'hff);
        wait_state(SC_STOP, 100);
        repeat (20) @(negedge core_clk);
        check("halted", 16'(SC_STOP), 16'(link.state_code_out));
        check("halt bus", 16'h00ff, 16'(link.bus));
        mem[pc_out[7:0]] = 8'h00;
        mem[pc_out[7:0] + 8'h01] = 8'h00;
        jam(8'h44);
        repeat (3) wait_state(SC_T1, 100);
        check("jump to zero", 16'h0000, 16'(link.bus));
        test_done();
    end
endmodule : tb_top
`default_nettype wire
